// ### hw/dac_sfd_defs.svh
`ifndef DAC_SFD_DEFS_SVH
`define DAC_SFD_DEFS_SVH

// =====================================================================
// special addresses
`define SA_NOP          6'h00
`define SA_CLR_CODE     6'h01
`define SA_SOFT_CLR     6'h02
`define SA_SOFT_PD      6'h08
`define SA_SOFT_PU      6'h09
`define SA_MONITOR      6'h0a
`define SA_CTRL         6'h0c
`define SA_SOFT_RST     6'h0f

// =====================================================================
// reset values and field layout
`define CTRL_RESET      14'h2000
`define CTRL_LIVE_MASK  14'h3f7c
`define CTRL_REF_BIT    12
`define CLR_CODE_RESET  14'h0000
`define GAIN_DEFAULT    14'h3ffe
`define OFFSET_DEFAULT  14'h2000
`define MON_CHAN_RESET  6'h00
`define MON_HIZ_CHAN    6'h3f
`define MON_FIELD_LSB   8
`define MON_FIELD_MSB   13

// =====================================================================
// timing
`define CLK_PERIOD_NS   8
`define CLR_TIME_NS     35000
`define RST_TIME_NS     135000
`define PU_TIME_NS      8000
`define NOP_CYCLES      1

`endif

// ### hw/dac_sfd_pkg.sv
package dac_sfd_pkg;

  // one host word as presented by the host interface
  typedef struct packed {
    logic        valid;
    logic        sel_hi;
    logic        sel_lo;
    logic        rnw;
    logic [5:0]  addr;
    logic [13:0] data;
  } cmd_t;

  // control register, msb first
  typedef struct packed {
    logic       pd_hiz;
    logic       ref_2v5;
    logic       boost;
    logic       int_ref;
    logic       monitor_en;
    logic       thermal_en;
    logic       spare7;
    logic [4:0] toggle_en;
    logic [1:0] spare1_0;
  } ctrl_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_HOLD = 2'b10
  } state_t;

endpackage

// ### hw/dac_special_function_decoder.sv
`timescale 1ns/1ps
`include "dac_sfd_defs.svh"

module dac_special_function_decoder
  import dac_sfd_pkg::*;
#(
  parameter logic        REF_DEFAULT  = 1'b1,
  parameter int          GROUPS       = 5,
  parameter int          CNT_W        = 16,
  parameter int          CLEAR_CYCLES = (`CLR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int          RESET_CYCLES = (`RST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire cmd_t              cmd,
  input  wire logic              clear_pin_n,
  input  wire logic              load_strobe_n,
  input  wire logic              hw_powerdown,
  input  wire logic              over_temp,
  output logic                   busy_n,
  output logic [13:0]            read_data,
  output logic                   read_valid,
  output logic                   write_rejected,
  output ctrl_t                  special_control,
  output logic [13:0]            clear_code,
  output logic                   load_clear_code,
  output logic                   zero_dacs,
  output logic [13:0]            gain_default,
  output logic [13:0]            offset_default,
  output logic                   powerdown_eff,
  output logic                   amps_enabled,
  output logic                   thermal_tripped,
  output logic [5:0]             monitor_channel,
  output logic                   monitor_routed,
  output logic                   monitor_hiz,
  output logic [GROUPS-1:0]      toggle_b_select
);

  localparam int PU_CYCLES = (`PU_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [13:0] CTRL_DEFAULT = `CTRL_RESET | (14'(REF_DEFAULT) << `CTRL_REF_BIT);

  // true when the host word lands in the special function space
  function automatic logic is_special(input cmd_t c);
    return c.valid && !c.sel_hi && !c.sel_lo;
  endfunction

  // =====================================================================
  // state
  state_t             state_ff,     nxt_state;
  logic [CNT_W-1:0]   cnt_ff,       nxt_cnt;
  ctrl_t              ctrl_ff,      nxt_ctrl;
  logic [13:0]        clr_code_ff,  nxt_clr_code;
  logic [5:0]         mon_ff,       nxt_mon;
  logic               soft_pd_ff,   nxt_soft_pd;
  logic               pd_eff_ff,    nxt_pd_eff;
  logic               therm_ff,     nxt_therm;
  logic [GROUPS-1:0]  tog_ff,       nxt_tog;
  logic               clr_prev_ff,  ld_prev_ff;
  logic [13:0]        rdata_ff,     nxt_rdata;
  logic               rvalid_ff,    nxt_rvalid;
  logic               reject_ff,    nxt_reject;
  logic               load_clr_ff,  nxt_load_clr;
  logic               zero_ff,      nxt_zero;
  logic               busy_n_ff;
  logic               amps_ff,      mon_route_ff, mon_hiz_ff;
  logic               clr_fall,     ld_fall,      take;

  assign clr_fall = clr_prev_ff && !clear_pin_n;
  assign ld_fall  = ld_prev_ff && !load_strobe_n;
  // the clear pin has priority over a host word in the same cycle
  assign take     = (state_ff == S_IDLE) && !clr_fall && is_special(cmd);

  // =====================================================================
  // command decode and next values
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_clr_code = clr_code_ff;
    nxt_mon      = mon_ff;
    nxt_soft_pd  = soft_pd_ff;
    nxt_therm    = therm_ff;
    nxt_tog      = tog_ff;
    nxt_rdata    = rdata_ff;
    nxt_rvalid   = 1'b0;
    nxt_reject   = 1'b0;
    nxt_load_clr = 1'b0;
    nxt_zero     = 1'b0;
    // thermal trip is sticky until a soft power-up sees a cool die
    if (ctrl_ff.thermal_en && over_temp) begin
      nxt_therm = 1'b1;
    end
    if (state_ff == S_HOLD) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
      if (cnt_ff == CNT_W'(1)) begin
        nxt_state = S_IDLE;
      end
    end else if (clr_fall) begin
      nxt_load_clr = 1'b1;
      nxt_state    = S_HOLD;
      nxt_cnt      = CNT_W'(CLEAR_CYCLES);
    end else if (take) begin
      // writes, except no-op, wake-up and control read, are refused in power-down
      if (pd_eff_ff && cmd.addr != `SA_NOP && cmd.addr != `SA_SOFT_PU
          && !(cmd.addr == `SA_CTRL && cmd.rnw)) begin
        nxt_reject = 1'b1;
      end else begin
        unique case (cmd.addr)
          `SA_NOP: begin
            nxt_state = S_HOLD;
            nxt_cnt   = CNT_W'(`NOP_CYCLES);
          end
          `SA_CLR_CODE: begin
            nxt_clr_code = cmd.data;
          end
          `SA_SOFT_CLR: begin
            nxt_load_clr = 1'b1;
            nxt_state    = S_HOLD;
            nxt_cnt      = CNT_W'(CLEAR_CYCLES);
          end
          `SA_SOFT_PD: begin
            nxt_soft_pd = 1'b1;
          end
          `SA_SOFT_PU: begin
            nxt_soft_pd = 1'b0;
            nxt_state   = S_HOLD;
            nxt_cnt     = CNT_W'(PU_CYCLES);
            if (!over_temp) begin
              nxt_therm = 1'b0;
            end
          end
          `SA_CTRL: begin
            if (cmd.rnw) begin
              nxt_rdata  = ctrl_ff;
              nxt_rvalid = 1'b1;
            end else begin
              nxt_ctrl = cmd.data & `CTRL_LIVE_MASK;
            end
          end
          `SA_MONITOR: begin
            nxt_mon = cmd.data[`MON_FIELD_MSB:`MON_FIELD_LSB];
          end
          `SA_SOFT_RST: begin
            nxt_ctrl     = CTRL_DEFAULT;
            nxt_clr_code = `CLR_CODE_RESET;
            nxt_mon      = `MON_CHAN_RESET;
            nxt_tog      = '0;
            nxt_zero     = 1'b1;
            nxt_state    = S_HOLD;
            nxt_cnt      = CNT_W'(RESET_CYCLES);
          end
          default: begin
            nxt_state = state_ff;
          end
        endcase
      end
    end
    // load strobe flips only enabled groups; strobes while busy are dropped
    for (int g = 0; g < GROUPS; g++) begin
      if (!nxt_ctrl.toggle_en[g]) begin
        nxt_tog[g] = 1'b0;
      end else if (ld_fall && state_ff == S_IDLE) begin
        nxt_tog[g] = ~tog_ff[g];
      end
    end
    nxt_pd_eff = hw_powerdown || nxt_soft_pd;
  end

  // =====================================================================
  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff     <= S_IDLE;
      cnt_ff       <= '0;
      ctrl_ff      <= CTRL_DEFAULT;
      clr_code_ff  <= `CLR_CODE_RESET;
      mon_ff       <= `MON_CHAN_RESET;
      soft_pd_ff   <= 1'b0;
      pd_eff_ff    <= 1'b0;
      therm_ff     <= 1'b0;
      tog_ff       <= '0;
      clr_prev_ff  <= 1'b1;
      ld_prev_ff   <= 1'b1;
      rdata_ff     <= '0;
      rvalid_ff    <= 1'b0;
      reject_ff    <= 1'b0;
      load_clr_ff  <= 1'b0;
      zero_ff      <= 1'b0;
      busy_n_ff    <= 1'b1;
      amps_ff      <= 1'b0;
      mon_route_ff <= 1'b0;
      mon_hiz_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      ctrl_ff      <= nxt_ctrl;
      clr_code_ff  <= nxt_clr_code;
      mon_ff       <= nxt_mon;
      soft_pd_ff   <= nxt_soft_pd;
      pd_eff_ff    <= nxt_pd_eff;
      therm_ff     <= nxt_therm;
      tog_ff       <= nxt_tog;
      clr_prev_ff  <= clear_pin_n;
      ld_prev_ff   <= load_strobe_n;
      rdata_ff     <= nxt_rdata;
      rvalid_ff    <= nxt_rvalid;
      reject_ff    <= nxt_reject;
      load_clr_ff  <= nxt_load_clr;
      zero_ff      <= nxt_zero;
      busy_n_ff    <= (nxt_state == S_IDLE);
      amps_ff      <= !nxt_pd_eff && !nxt_therm;
      mon_route_ff <= nxt_ctrl.monitor_en && (nxt_mon != `MON_HIZ_CHAN);
      mon_hiz_ff   <= nxt_ctrl.monitor_en && (nxt_mon == `MON_HIZ_CHAN);
    end
  end

  // the variant's reference default is a parameter, so it is a constant that the
  // asynchronous reset may load; power-up and soft reset land in the same control, clear code, monitor and toggle state

  assign busy_n          = busy_n_ff;
  assign read_data       = rdata_ff;
  assign read_valid      = rvalid_ff;
  assign write_rejected  = reject_ff;
  assign special_control = ctrl_ff;
  assign clear_code      = clr_code_ff;
  assign load_clear_code = load_clr_ff;
  assign zero_dacs       = zero_ff;
  assign gain_default    = `GAIN_DEFAULT;
  assign offset_default  = `OFFSET_DEFAULT;
  assign powerdown_eff   = pd_eff_ff;
  assign amps_enabled    = amps_ff;
  assign thermal_tripped = therm_ff;
  assign monitor_channel = mon_ff;
  assign monitor_routed  = mon_route_ff;
  assign monitor_hiz     = mon_hiz_ff;
  assign toggle_b_select = tog_ff;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_NOP_PULSE: assert property (take && !pd_eff_ff && cmd.addr == `SA_NOP
    |=> !busy_n ##1 busy_n) else $error("nop busy pulse wrong");
  AST_CLR_CODE: assert property (take && !pd_eff_ff && cmd.addr == `SA_CLR_CODE
    |=> clear_code == $past(cmd.data)) else $error("clear code not stored");
  AST_READBACK: assert property (take && cmd.addr == `SA_CTRL && cmd.rnw
    |=> read_valid && read_data == $past(ctrl_ff)) else $error("control readback wrong");
  AST_SOFT_CLR: assert property (take && !pd_eff_ff && cmd.addr == `SA_SOFT_CLR
    |=> load_clear_code && !busy_n && cnt_ff == CNT_W'(CLEAR_CYCLES))
    else $error("soft clear start wrong");
  AST_PIN_CLR: assert property (state_ff == S_IDLE && clr_fall
    |=> load_clear_code && !busy_n) else $error("pin clear lost");
  AST_PD_REJECT: assert property (take && pd_eff_ff && cmd.addr == `SA_CTRL && !cmd.rnw
    |=> write_rejected && $stable(special_control)) else $error("write in power-down");
  AST_PD_OR: assert property (##1 powerdown_eff == ($past(hw_powerdown) || soft_pd_ff))
    else $error("power-down not or-ed");
  AST_CTRL_MASK: assert property (special_control.spare7 == 1'b0 && special_control.spare1_0 == 2'b00)
    else $error("spare control bits set");
  AST_SOFT_RST: assert property (take && !pd_eff_ff && cmd.addr == `SA_SOFT_RST
    |=> zero_dacs && special_control == CTRL_DEFAULT && clear_code == `CLR_CODE_RESET)
    else $error("soft reset defaults wrong");
  AST_MON_HIZ: assert property (special_control.monitor_en && monitor_channel == `MON_HIZ_CHAN
    |-> monitor_hiz && !monitor_routed) else $error("monitor not floated");
  AST_THERMAL: assert property (special_control.thermal_en && over_temp
    |=> thermal_tripped && !amps_enabled) else $error("thermal guard idle");
  AST_TOGGLE: assert property (state_ff == S_IDLE && ld_fall && ctrl_ff.toggle_en[0]
    && nxt_ctrl.toggle_en[0] |=> toggle_b_select[0] != $past(toggle_b_select[0]))
    else $error("group 0 did not toggle");

  COV_SOFT_CLR: cover property (take && cmd.addr == `SA_SOFT_CLR ##1 !busy_n);
  COV_PD_PU:    cover property (powerdown_eff ##[1:50] take && cmd.addr == `SA_SOFT_PU);
  COV_READ:     cover property (read_valid);
  COV_TOGGLE:   cover property (ld_fall && |ctrl_ff.toggle_en);

endmodule

// ### test/host_model.sv
`timescale 1ns/1ps
`include "dac_sfd_defs.svh"
// =====================================================================
// host controller writing one word at a time
module host_model
  import dac_sfd_pkg::*;
(
  input  wire logic clk,
  input  wire logic busy_n,
  input  wire logic powerdown_eff,
  output cmd_t      cmd
);
  initial cmd = '0;

  // waits for idle so no word is lost while the device is busy
  task automatic issue(input logic rnw, input logic [5:0] addr, input logic [13:0] data);
    int n;
    n = 0;
    // busy is looked at one edge on, so a busy phase just started is not missed
    @(posedge clk);
    while (busy_n !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    // a reset word is never sent while powered down
    if (addr == `SA_SOFT_RST && powerdown_eff === 1'b1) return;
    cmd <= {1'b1, 1'b0, 1'b0, rnw, addr, data};
    @(posedge clk);
    cmd <= '0;
  endtask
endmodule

// ### test/dac_special_function_decoder_bench.sv
`timescale 1ns/1ps
`include "dac_sfd_defs.svh"
module dac_special_function_decoder_bench
  import dac_sfd_pkg::*;
;
  logic clk, rst, clear_pin_n, load_strobe_n, hw_powerdown, over_temp;
  logic busy_n, read_valid, write_rejected, load_clear_code, zero_dacs;
  logic powerdown_eff, amps_enabled, thermal_tripped, monitor_routed, monitor_hiz;
  logic [13:0] read_data, clear_code, gain_default, offset_default, last_rd, v, old;
  logic [5:0]  monitor_channel, ch;
  logic [4:0]  toggle_b_select;
  ctrl_t       special_control;
  cmd_t        cmd;
  int          bad_count, compares, n_lcc, n_rej, n_zero, n_rd, len, c0;

  dac_special_function_decoder #(.CLEAR_CYCLES(8), .RESET_CYCLES(16)) i_dac_special_function_decoder (
    .clk(clk), .rst(rst), .cmd(cmd), .clear_pin_n(clear_pin_n), .load_strobe_n(load_strobe_n),
    .hw_powerdown(hw_powerdown), .over_temp(over_temp), .busy_n(busy_n), .read_data(read_data),
    .read_valid(read_valid), .write_rejected(write_rejected), .special_control(special_control),
    .clear_code(clear_code), .load_clear_code(load_clear_code), .zero_dacs(zero_dacs),
    .gain_default(gain_default), .offset_default(offset_default), .powerdown_eff(powerdown_eff),
    .amps_enabled(amps_enabled), .thermal_tripped(thermal_tripped), .monitor_channel(monitor_channel),
    .monitor_routed(monitor_routed), .monitor_hiz(monitor_hiz), .toggle_b_select(toggle_b_select));

  host_model i_host_model (.clk(clk), .busy_n(busy_n), .powerdown_eff(powerdown_eff), .cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // =====================================================================
  // pulse counters, so checks do not hang on the exact answer cycle
  always @(posedge clk) begin
    if (load_clear_code === 1'b1) n_lcc++;
    if (write_rejected === 1'b1) n_rej++;
    if (zero_dacs === 1'b1) n_zero++;
    if (read_valid === 1'b1) begin
      n_rd++;
      last_rd = read_data;
    end
  end

  // =====================================================================
  // helpers
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // measures the busy low phase of the word just sent
  task automatic busy_len(output int n);
    int k;
    n = 0;
    #1;
    for (k = 0; k < 4 && busy_n !== 1'b0; k++) @(posedge clk) #1;
    while (busy_n === 1'b0 && n < 2000) begin
      n++;
      @(posedge clk) #1;
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic pin(input int which);
    @(posedge clk);
    if (which == 0) clear_pin_n <= 1'b0;
    else load_strobe_n <= 1'b0;
    @(posedge clk);
    clear_pin_n   <= 1'b1;
    load_strobe_n <= 1'b1;
  endtask

  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a hang is cut well after the longest expected run
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // =====================================================================
  // main sequence
  initial begin
    void'($urandom(16));
    {bad_count, compares, n_lcc, n_rej, n_zero, n_rd} = '0;
    rst = 1'b1;
    {hw_powerdown, over_temp} = 2'b00;
    {clear_pin_n, load_strobe_n} = 2'b11;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(special_control, 14'h3000);
    chk(clear_code, 14'h0000);
    chk(gain_default, 14'h3ffe);
    chk(offset_default, 14'h2000);
    // control writes and reads, all ones first
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 14'h3fff : 14'($urandom);
      i_host_model.issue(1'b0, `SA_CTRL, v);
      c0 = n_rd;
      i_host_model.issue(1'b1, `SA_CTRL, 14'h0000);
      settle();
      chk(14'(n_rd - c0), 14'h0001);
      chk(last_rd, v & 14'h3f7c);
      chk(special_control, v & 14'h3f7c);
    end
    // clear code, soft clear and clear pin
    v = 14'($urandom);
    i_host_model.issue(1'b0, `SA_CLR_CODE, v);
    settle();
    chk(clear_code, v);
    c0 = n_lcc;
    i_host_model.issue(1'b0, `SA_SOFT_CLR, 14'($urandom));
    busy_len(len);
    chk(14'(len), 14'h0008);
    pin(0);
    busy_len(len);
    chk(14'(n_lcc - c0), 14'h0002);
    i_host_model.issue(1'b0, `SA_NOP, 14'h0000);
    busy_len(len);
    chk(14'(len), 14'h0001);
    // unused address leaves state alone
    old = special_control;
    i_host_model.issue(1'b0, 6'h03, 14'($urandom));
    settle();
    chk(special_control, old);
    chk(clear_code, v);
    // monitor routing, then channel 63
    i_host_model.issue(1'b0, `SA_CTRL, 14'h0214);
    ch = 6'($urandom_range(0, 62));
    i_host_model.issue(1'b0, `SA_MONITOR, {ch, 8'h00});
    settle();
    chk(14'(monitor_channel), 14'(ch));
    chk(14'(monitor_routed), 14'h0001);
    i_host_model.issue(1'b0, `SA_MONITOR, 14'h3f00);
    settle();
    chk(14'({monitor_hiz, monitor_routed}), 14'h0002);
    // groups 0 and 2 toggle on each strobe
    pin(1);
    settle();
    chk(14'(toggle_b_select), 14'h0005);
    pin(1);
    settle();
    chk(14'(toggle_b_select), 14'h0000);
    // soft power-down keeps contents and refuses writes
    old = special_control;
    i_host_model.issue(1'b0, `SA_SOFT_PD, 14'h0000);
    settle();
    chk(14'({powerdown_eff, amps_enabled}), 14'h0002);
    c0 = n_rej;
    i_host_model.issue(1'b0, `SA_CTRL, ~old);
    i_host_model.issue(1'b0, `SA_SOFT_RST, 14'h0000);
    settle();
    chk(14'(n_rej - c0), 14'h0001);
    chk(special_control, old);
    i_host_model.issue(1'b0, `SA_SOFT_PU, 14'h0000);
    busy_len(len);
    chk(14'(len), 14'h03e8);
    chk(14'({powerdown_eff, amps_enabled}), 14'h0001);
    // level inputs move on a rising edge, as the host would drive them
    @(posedge clk);
    hw_powerdown <= 1'b1;
    settle();
    chk(14'(powerdown_eff), 14'h0001);
    @(posedge clk);
    hw_powerdown <= 1'b0;
    settle();
    chk(14'(powerdown_eff), 14'h0000);
    // thermal guard trips and stays until a soft power-up
    i_host_model.issue(1'b0, `SA_CTRL, 14'h0100);
    @(posedge clk);
    over_temp <= 1'b1;
    settle();
    chk(14'({thermal_tripped, amps_enabled}), 14'h0002);
    @(posedge clk);
    over_temp <= 1'b0;
    settle();
    chk(14'(amps_enabled), 14'h0000);
    i_host_model.issue(1'b0, `SA_SOFT_PU, 14'h0000);
    busy_len(len);
    chk(14'(amps_enabled), 14'h0001);
    // soft reset back to defaults
    c0 = n_zero;
    i_host_model.issue(1'b0, `SA_SOFT_RST, 14'h0000);
    busy_len(len);
    chk(14'(len), 14'h0010);
    chk(14'(n_zero - c0), 14'h0001);
    chk(special_control, 14'h3000);
    chk(clear_code, 14'h0000);
    end_sim();
  end
endmodule
